// ==== logic/ldp_pkg.sv ====
/*
 * Constants, field layouts and carrier types of the LED dimmer PWM block.
 * Assumes one 10 MHz system clock; all register offsets are APB byte addresses.
 */
// Contract
// - eight fast and eight slow channels, four timers in each speed group.
// - fast timer clock: bus clock when source select is 1, reference tick when 0.
// - divider factor has 10-bit integer part A and 8-bit fraction B.
// - per 256 outputs, B periods of A+1 and 256-B periods of A, evenly spread.
// - counter steps per divider output, wraps at 2^resolution-1 with overflow event.
// - software can reset, pause and read each timer counter.
// - each timer feeds its 20-bit count to its channels; its cycle sets PWM rate.
// - slow timers use reference tick or slow clock; global bit picks bus or 8 MHz.
// - fast timer divider and resolution changes apply at the next overflow.
// - slow timer divider and resolution apply only on the parameter-update bit.
// - channel output goes high when count equals high-point compare.
// - output goes low when count reaches high point plus duty bits 24..4.
// - duty bits 3..0 lengthen pulses by one cycle at rate value/16.
// - fade-start bit begins a fade, rising if direction set, falling if clear.
// - each step period of PWM cycles, step size is added to or subtracted from duty.
// - fade stops after programmed step count and raises fade-finished event.
// - every fast and slow channel has its own fade-finished event output.
// - every fast and slow timer has its own overflow event at maximum count.
// - each channel may select any of the four timers of its own group.
package ldp_pkg;
    localparam int CNT_W         = 20;
    localparam int DIV_INT_W     = 10;
    localparam int DIV_FRAC_W    = 8;
    localparam int DIV_W         = DIV_INT_W + DIV_FRAC_W;
    localparam int DUTY_W        = 25;
    localparam int DUTY_FRAC_W   = 4;
    localparam int RES_W         = 5;
    localparam int FADE_FIELD_W  = 10;
    localparam int TMR_PER_GROUP = 4;
    localparam int CH_PER_GROUP  = 8;
    localparam logic [RES_W-1:0] RES_MAX = 5'h14;

    // register map: channel blocks of five words, then timers, then global
    localparam int CH_STRIDE      = 'h14;
    localparam int CH_SEL_OFS     = 'h0;
    localparam int CH_HPOINT_OFS  = 'h4;
    localparam int CH_DUTY_OFS    = 'h8;
    localparam int CH_FADE_OFS    = 'hC;
    localparam int CH_DUTY_RD_OFS = 'h10;
    localparam int TMR_BASE       = 'h140;
    localparam int TMR_STRIDE     = 'h8;
    localparam int TMR_CONF_OFS   = 'h0;
    localparam int TMR_VALUE_OFS  = 'h4;
    localparam int GLOB_CONF_ADDR = 'h190;
    localparam int ADDR_W         = 12;

    // timer config field positions and the fade start bit
    localparam int TC_SRC_BIT    = 23;
    localparam int TC_PAUSE_BIT  = 24;
    localparam int TC_RST_BIT    = 25;
    localparam int TC_UPD_BIT    = 26;
    localparam int TC_RES_LSB    = 18;
    localparam int FD_START_BIT  = 31;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef struct packed {
        logic             hold_rst; // bit 25, above pause and source select
        logic             pause;
        logic             src_sel;
        logic [RES_W-1:0] res;
        logic [DIV_W-1:0] div;
    } ldp_tmr_conf_s;

    typedef struct packed {
        logic                    inc;
        logic [FADE_FIELD_W-1:0] num;
        logic [FADE_FIELD_W-1:0] cycle;
        logic [FADE_FIELD_W-1:0] scale;
    } ldp_fade_conf_s;

    typedef enum logic {FD_IDLE = 1'b0, FD_RUN = 1'b1} ldp_fade_e;
endpackage : ldp_pkg

// ==== logic/ldp_led_dimmer.sv ====
/*
 * LED dimmer PWM controller: eight timers, sixteen channels, APB register slave.
 * Assumes ref_tick_pin and clk8m_pin are slow square waves from other clock
 * domains; the bus clock source is the system clock itself.
 */
`timescale 1ns/1ps
`default_nettype none
module ldp_led_dimmer
#(
    parameter int CH_N = ldp_pkg::CH_PER_GROUP
)
(
    input  wire logic                          ref_clk,
    input  wire logic                          rstn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ldp_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          ref_tick_pin,
    input  wire logic                          clk8m_pin,
    output logic      [CH_N-1:0]               fast_pwm_out,
    output logic      [CH_N-1:0]               slow_pwm_out,
    output logic      [CH_N-1:0]               fast_fade_done_irq,
    output logic      [CH_N-1:0]               slow_fade_done_irq,
    output logic      [3:0]                    fast_timer_wrap_irq,
    output logic      [3:0]                    slow_timer_wrap_irq
);
    import ldp_pkg::*;

    localparam int TMR_N = 2 * TMR_PER_GROUP;
    localparam int CHT_N = 2 * CH_N;

    // fixed two-bit timer select and map room limit the channel count
    if (CH_N < 1 || CH_N > CH_PER_GROUP)
        $error("CH_N must lie between 1 and 8");

    // pin synchronisers; only stage two feeds the edge flop
    logic [1:0] tick_sync;
    logic [1:0] m8_sync;
    logic       tick_last;
    logic       m8_last;
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            tick_sync <= 2'h0;
            m8_sync   <= 2'h0;
            tick_last <= 1'b0;
            m8_last   <= 1'b0;
        end
        else
        begin
            tick_sync <= {tick_sync[0], ref_tick_pin};
            m8_sync   <= {m8_sync[0], clk8m_pin};
            tick_last <= tick_sync[1];
            m8_last   <= m8_sync[1];
        end
    end
    wire ref_tick_pulse = tick_sync[1] & ~tick_last;
    wire m8_pulse       = m8_sync[1] & ~m8_last;

    // apb handshake: one wait state, answer registered
    wire bus_access = psel & penable;
    wire wr_en      = bus_access & pready & pwrite;
    wire rd_cycle   = bus_access & ~pready;

    logic          slow_src_bus;
    ldp_tmr_conf_s tconf [TMR_N];
    logic [1:0]    ch_sel [CHT_N];
    logic [CNT_W-1:0] hpoint [CHT_N];
    logic [DUTY_W-1:0] duty [CHT_N];
    ldp_fade_conf_s fconf [CHT_N];
    logic [CNT_W-1:0] tval [TMR_N];
    logic [TMR_N-1:0] twrap;
    logic [CHT_N-1:0] pwm_q;
    logic [CHT_N-1:0] done_q;

    // read decode over the whole map
    logic [31:0] rd_word;
    logic        rd_hit;
    always_comb
    begin
        rd_word = RESET_WORD;
        rd_hit  = 1'b0;
        if (paddr == ADDR_W'(GLOB_CONF_ADDR))
        begin
            rd_hit  = 1'b1;
            rd_word = {31'h0, slow_src_bus};
        end
        for (int c = 0; c < CHT_N; c++)
        begin
            if (paddr == ADDR_W'(c * CH_STRIDE + CH_SEL_OFS))
            begin
                rd_hit  = 1'b1;
                rd_word = {30'h0, ch_sel[c]};
            end
            if (paddr == ADDR_W'(c * CH_STRIDE + CH_HPOINT_OFS))
            begin
                rd_hit  = 1'b1;
                rd_word = {12'h0, hpoint[c]};
            end
            if (paddr == ADDR_W'(c * CH_STRIDE + CH_DUTY_OFS) ||
                paddr == ADDR_W'(c * CH_STRIDE + CH_DUTY_RD_OFS))
            begin
                rd_hit  = 1'b1;
                rd_word = {7'h0, duty[c]};
            end
            if (paddr == ADDR_W'(c * CH_STRIDE + CH_FADE_OFS))
            begin
                rd_hit  = 1'b1;
                rd_word = {1'b0, fconf[c]};
            end
        end
        for (int t = 0; t < TMR_N; t++)
        begin
            if (paddr == ADDR_W'(TMR_BASE + t * TMR_STRIDE + TMR_CONF_OFS))
            begin
                rd_hit  = 1'b1;
                rd_word = {6'h0, tconf[t]};
            end
            if (paddr == ADDR_W'(TMR_BASE + t * TMR_STRIDE + TMR_VALUE_OFS))
            begin
                rd_hit  = 1'b1;
                rd_word = {12'h0, tval[t]};
            end
        end
    end

    // answer flops; pready drops after the completing edge
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            pready  <= 1'b0;
            prdata  <= RESET_WORD;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= rd_cycle;
            prdata  <= (rd_cycle && !pwrite) ? rd_word : RESET_WORD;
            pslverr <= rd_cycle & ~rd_hit;
        end
    end

    // global slow clock source select
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            slow_src_bus <= 1'b0;
        else if (wr_en && paddr == ADDR_W'(GLOB_CONF_ADDR))
            slow_src_bus <= pwdata[0];
    end
    wire slow_tick = slow_src_bus | m8_pulse;

    // timers: 0..3 fast group, 4..7 slow group
    for (genvar t = 0; t < TMR_N; t++)
    begin : g_tmr
        localparam bit IS_FAST = (t < TMR_PER_GROUP);
        wire conf_hit = wr_en && paddr == ADDR_W'(TMR_BASE + t * TMR_STRIDE + TMR_CONF_OFS);
        logic [DIV_W-1:0]     div_act;
        logic [RES_W-1:0]     res_act;
        logic [DIV_INT_W:0]   div_cnt;
        logic [DIV_FRAC_W-1:0] frac_acc;
        logic [CNT_W-1:0]     cnt;
        logic                 wrap_q;

        // input clock selection per group
        wire src_tick = IS_FAST ? (tconf[t].src_sel | ref_tick_pulse)
                                : (tconf[t].src_sel ? slow_tick : ref_tick_pulse);
        // fraction carry picks an A+1 period; accumulator spreads them evenly
        wire [DIV_FRAC_W:0] acc_sum = {1'b0, frac_acc} + {1'b0, div_act[DIV_FRAC_W-1:0]};
        wire [DIV_INT_W:0]  per_raw = {1'b0, div_act[DIV_W-1:DIV_FRAC_W]} +
                                      {{DIV_INT_W{1'b0}}, acc_sum[DIV_FRAC_W]};
        wire [DIV_INT_W:0]  per_len = (per_raw == '0) ? (DIV_INT_W+1)'(1) : per_raw;
        wire                div_out = src_tick && (div_cnt + (DIV_INT_W+1)'(1) >= per_len);
        wire [RES_W-1:0]    res_eff = (res_act > RES_MAX) ? RES_MAX : res_act;
        wire [CNT_W:0]      max_wide = ((CNT_W+1)'(1) << res_eff) - (CNT_W+1)'(1);
        wire [CNT_W-1:0]    cnt_max = max_wide[CNT_W-1:0];
        wire                run = ~tconf[t].pause & ~tconf[t].hold_rst;
        wire                at_wrap = div_out && run && cnt == cnt_max;
        // slow update bit self-clears, so the stored word never holds it
        wire                slow_upd = conf_hit & pwdata[TC_UPD_BIT];

        always_ff @(posedge ref_clk)
        begin
            if (!rstn)
                tconf[t] <= '0;
            else if (conf_hit)
                tconf[t] <= pwdata[TC_RST_BIT:0];
        end

        // active parameters: fast at wrap, slow on update request
        always_ff @(posedge ref_clk)
        begin
            if (!rstn)
            begin
                div_act <= '0;
                res_act <= '0;
            end
            else if (IS_FAST ? (at_wrap || tconf[t].hold_rst) : slow_upd)
            begin
                div_act <= tconf[t].div;
                res_act <= tconf[t].res;
            end
        end

        // divider and counter; software reset holds both at zero
        always_ff @(posedge ref_clk)
        begin
            if (!rstn || tconf[t].hold_rst)
            begin
                div_cnt  <= '0;
                frac_acc <= '0;
                cnt      <= '0;
            end
            else if (run && div_out)
            begin
                div_cnt  <= '0;
                frac_acc <= acc_sum[DIV_FRAC_W-1:0];
                cnt      <= at_wrap ? '0 : cnt + CNT_W'(1);
            end
            else if (run && src_tick)
                div_cnt <= div_cnt + (DIV_INT_W+1)'(1);
        end

        always_ff @(posedge ref_clk)
        begin
            if (!rstn)
                wrap_q <= 1'b0;
            else
                wrap_q <= at_wrap;
        end
        assign tval[t]  = cnt;
        assign twrap[t] = wrap_q;
    end

    // channels: 0..CH_N-1 fast, CH_N.. slow
    for (genvar c = 0; c < CHT_N; c++)
    begin : g_ch
        localparam int GRP = (c < CH_N) ? 0 : TMR_PER_GROUP;
        wire sel_hit  = wr_en && paddr == ADDR_W'(c * CH_STRIDE + CH_SEL_OFS);
        wire hp_hit   = wr_en && paddr == ADDR_W'(c * CH_STRIDE + CH_HPOINT_OFS);
        wire duty_hit = wr_en && paddr == ADDR_W'(c * CH_STRIDE + CH_DUTY_OFS);
        wire fade_hit = wr_en && paddr == ADDR_W'(c * CH_STRIDE + CH_FADE_OFS);
        wire start    = fade_hit & pwdata[FD_START_BIT];

        // timer choice within the own group only
        wire [CNT_W-1:0] cval  = tval[GRP + int'(ch_sel[c])];
        wire             cwrap = twrap[GRP + int'(ch_sel[c])];

        logic [DUTY_FRAC_W-1:0]  dith_acc;
        logic                    extra;
        ldp_fade_e               fstate;
        logic [FADE_FIELD_W-1:0] cyc_cnt;
        logic [FADE_FIELD_W-1:0] step_cnt;
        logic                    done_r;

        wire [DUTY_W-DUTY_FRAC_W-1:0] duty_int = duty[c][DUTY_W-1:DUTY_FRAC_W];
        wire [DUTY_FRAC_W:0] dith_sum = {1'b0, dith_acc} + {1'b0, duty[c][DUTY_FRAC_W-1:0]};
        wire [DUTY_W-DUTY_FRAC_W:0] low_pt = {1'b0, duty_int} + (DUTY_W-DUTY_FRAC_W+1)'(hpoint[c]) +
                                             (DUTY_W-DUTY_FRAC_W+1)'(extra);
        wire step_due = fstate == FD_RUN && cwrap &&
                        cyc_cnt + FADE_FIELD_W'(1) >= fconf[c].cycle;
        wire last_step = step_due && step_cnt + FADE_FIELD_W'(1) >= fconf[c].num;
        wire [DUTY_W-DUTY_FRAC_W-1:0] next_int = fconf[c].inc ?
                 duty_int + (DUTY_W-DUTY_FRAC_W)'(fconf[c].scale) :
                 duty_int - (DUTY_W-DUTY_FRAC_W)'(fconf[c].scale);

        // plain config words
        always_ff @(posedge ref_clk)
        begin
            if (!rstn)
            begin
                ch_sel[c] <= 2'h0;
                hpoint[c] <= '0;
                fconf[c]  <= '0;
            end
            else
            begin
                if (sel_hit)
                    ch_sel[c] <= pwdata[1:0];
                if (hp_hit)
                    hpoint[c] <= pwdata[CNT_W-1:0];
                if (fade_hit)
                    fconf[c] <= pwdata[FD_START_BIT-1:0];
            end
        end

        // duty register: software load, fade steps otherwise
        always_ff @(posedge ref_clk)
        begin
            if (!rstn)
                duty[c] <= '0;
            else if (duty_hit)
                duty[c] <= pwdata[DUTY_W-1:0];
            else if (step_due)
                duty[c] <= {next_int, duty[c][DUTY_FRAC_W-1:0]};
        end

        // fade sequencer; a new start restarts counts (software waits first)
        always_ff @(posedge ref_clk)
        begin
            if (!rstn)
            begin
                fstate   <= FD_IDLE;
                cyc_cnt  <= '0;
                step_cnt <= '0;
                done_r   <= 1'b0;
            end
            else
            begin
                done_r <= 1'b0;
                if (start)
                begin
                    fstate   <= FD_RUN;
                    cyc_cnt  <= '0;
                    step_cnt <= '0;
                end
                else if (fstate == FD_RUN && cwrap)
                begin
                    cyc_cnt <= step_due ? '0 : cyc_cnt + FADE_FIELD_W'(1);
                    if (step_due)
                        step_cnt <= step_cnt + FADE_FIELD_W'(1);
                    if (last_step)
                    begin
                        fstate <= FD_IDLE;
                        done_r <= 1'b1;
                    end
                end
            end
        end

        // dither: carry of a per-cycle accumulator adds one count, frac/16 of cycles
        always_ff @(posedge ref_clk)
        begin
            if (!rstn)
            begin
                dith_acc <= '0;
                extra    <= 1'b0;
            end
            else if (cwrap)
            begin
                dith_acc <= dith_sum[DUTY_FRAC_W-1:0];
                extra    <= dith_sum[DUTY_FRAC_W];
            end
        end

        // output latch: low compare wins when both match on a zero duty
        always_ff @(posedge ref_clk)
        begin
            if (!rstn)
                pwm_q[c] <= 1'b0;
            else if ({1'b0, cval} == low_pt[CNT_W:0] && low_pt[DUTY_W-DUTY_FRAC_W:CNT_W+1] == '0)
                pwm_q[c] <= 1'b0;
            else if (cval == hpoint[c])
                pwm_q[c] <= 1'b1;
        end
        assign done_q[c] = done_r;
    end

    // fixed group split of outputs
    assign fast_pwm_out        = pwm_q[CH_N-1:0];
    assign slow_pwm_out        = pwm_q[CHT_N-1:CH_N];
    assign fast_fade_done_irq  = done_q[CH_N-1:0];
    assign slow_fade_done_irq  = done_q[CHT_N-1:CH_N];
    assign fast_timer_wrap_irq = twrap[TMR_PER_GROUP-1:0];
    assign slow_timer_wrap_irq = twrap[TMR_N-1:TMR_PER_GROUP];
endmodule : ldp_led_dimmer
`default_nettype wire

// ==== bench/ldp_led_load.sv ====
/*
 * LED load model on the far side of one PWM line: tallies lit cycles and turn-ons.
 * Assumes the line is a registered level in the ref_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module ldp_led_load
(
    input  wire logic        ref_clk,
    input  wire logic        clr,
    input  wire logic        pwm,
    output logic      [15:0] high_cnt,
    output logic      [15:0] rise_cnt
);
    logic prev;

    // a load only listens, so nothing is driven back into the block
    always_ff @(posedge ref_clk)
    begin
        prev     <= pwm;
        high_cnt <= clr ? 16'h0 : high_cnt + {15'h0, pwm};
        rise_cnt <= clr ? 16'h0 : rise_cnt + {15'h0, pwm & ~prev};
    end
endmodule : ldp_led_load
`default_nettype wire

// ==== bench/ldp_led_dimmer_asserts.sv ====
/*
 * Port checker of the LED dimmer: bus answer timing, reset quiet, event pulses.
 * Assumes it is bound into ldp_led_dimmer and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module ldp_led_dimmer_chk
#(
    parameter int CH_N = 8
)
(
    input  wire logic                       ref_clk,
    input  wire logic                       rstn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ldp_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [31:0]                prdata,
    input  wire logic                       pready,
    input  wire logic                       pslverr,
    input  wire logic                       ref_tick_pin,
    input  wire logic                       clk8m_pin,
    input  wire logic [CH_N-1:0]            fast_pwm_out,
    input  wire logic [CH_N-1:0]            slow_pwm_out,
    input  wire logic [CH_N-1:0]            fast_fade_done_irq,
    input  wire logic [CH_N-1:0]            slow_fade_done_irq,
    input  wire logic [3:0]                 fast_timer_wrap_irq,
    input  wire logic [3:0]                 slow_timer_wrap_irq
);
    import ldp_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // register access answers after exactly one wait state, for one cycle
    AST_READY_LATE: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle into the access phase");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("answer held longer than one cycle");
    AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
        else $error("answer without an access phase");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("error flag outside an answer");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero between answers");
    AST_ERR_DATA: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    // reset sampled low clears pready, both PWM outputs and the fast fade-done and wrap events on the next edge
    AST_RESET_QUIET: assert property (disable iff (1'b0) !rstn |=> !pready && fast_pwm_out == '0
        && slow_pwm_out == '0 && fast_fade_done_irq == '0 && fast_timer_wrap_irq == 4'h0)
        else $error("outputs not cleared by reset");
    // a finished fade is one pulse; no second finish in the two cycles after it
    AST_FADE_PULSE: assert property (fast_fade_done_irq[0] |=> !fast_fade_done_irq[0] [*2])
        else $error("fade done pulse too long or repeated");
endmodule : ldp_led_dimmer_chk

bind ldp_led_dimmer ldp_led_dimmer_chk #(.CH_N(CH_N)) ldp_led_dimmer_chk_i (.*);
`default_nettype wire

// ==== bench/tb_top.sv ====
/*
 * Self-checking bench of the LED dimmer: registers, timers, channels, fades.
 * Assumes the design's register map and one-wait-state bus answer.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ldp_pkg::*;
    logic              ref_clk, rstn, psel, penable, pwrite, ref_tick_pin, clk8m_pin;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd_q;
    logic              pready, pslverr, rd_e, clr, use_slow;
    logic [7:0]        fast_pwm_out, slow_pwm_out, fast_fade_done_irq, slow_fade_done_irq;
    logic [3:0]        fast_timer_wrap_irq, slow_timer_wrap_irq, div_cnt;
    logic [15:0]       high_cnt, rise_cnt, h, r;
    int                num_checks = 0, fail_count = 0, g, s;
    wire logic [7:0]   wraps = {slow_timer_wrap_irq, fast_timer_wrap_irq};
    wire logic         lamp = use_slow ? slow_pwm_out[0] : fast_pwm_out[0];
    wire logic         fin  = use_slow ? slow_fade_done_irq[0] : fast_fade_done_irq[0];

    ldp_led_dimmer ldp_led_dimmer_i (.*);
    ldp_led_load ldp_led_load_i (.ref_clk(ref_clk), .clr(clr), .pwm(lamp), .high_cnt(high_cnt),
        .rise_cnt(rise_cnt));

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // source pins: reference tick every 10 cycles, slow source every 2
    always @(posedge ref_clk)
    begin
        div_cnt      <= (div_cnt == 4'h9) ? 4'h0 : div_cnt + 4'h1;
        ref_tick_pin <= (div_cnt < 4'h5);
        clk8m_pin    <= ~clk8m_pin;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            fail_count++;
    endtask : chk

    // one bus transfer; the idle edge first keeps drivers from clashing
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20)
            fail_count++;
        rd_q    = prdata;
        rd_e    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // cycles between wrap pulses of one timer, optionally after a sync pulse
    task automatic gap(input int b, input logic sync, output int q);
        int n;
        n = 0;
        q = 0;
        if (sync)
            do @(posedge ref_clk); while (wraps[b] !== 1'b1 && ++n < 400);
        do @(posedge ref_clk); while (wraps[b] !== 1'b1 && ++q < 400);
        q++;
        if (n >= 400 || q > 400)
            fail_count++;
    endtask : gap

    // 256-cycle window of the load; a multiple of every period used here
    task automatic win(input logic sl);
        use_slow <= sl;
        repeat (16) @(posedge ref_clk); // one full period drops a stale latched level
        clr      <= 1'b1;
        @(posedge ref_clk);
        clr      <= 1'b0;
        repeat (257) @(posedge ref_clk);
        h = high_cnt;
        r = rise_cnt;
    endtask : win

    task automatic wait_done;
        int n;
        n = 0;
        do @(posedge ref_clk); while (fin !== 1'b1 && ++n < 1000);
        chk({31'h0, n < 1000}, 32'h1);
    endtask : wait_done

    task automatic t_regs;
        apb(1'b0, 12'h140, 32'h0);
        chk(rd_q, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0);
        chk({31'h0, rd_e}, 32'h1);
        apb(1'b1, 12'h010, 32'h55);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd_q, 32'h0);
        apb(1'b1, 12'h134, 32'h1234);
        apb(1'b0, 12'h13C, 32'h0);
        chk(rd_q, 32'h1234);
        $display("register test done");
    endtask : t_regs

    task automatic t_timer;
        apb(1'b1, 12'h140, 32'h008C0200);
        gap(0, 1'b1, g);
        gap(0, 1'b1, g);
        chk(g, 32'h10);
        apb(1'b1, 12'h140, 32'h00000100);
        gap(0, 1'b1, g);
        gap(0, 1'b1, g);
        chk(g, 32'hA);
        apb(1'b1, 12'h140, 32'h00800180);
        gap(0, 1'b1, g);
        s = 0;
        repeat (8)
        begin
            gap(0, 1'b0, g);
            s += g;
        end
        chk(s, 32'hC);
        apb(1'b1, 12'h140, 32'h00900100);
        gap(0, 1'b1, g);
        gap(0, 1'b1, g);
        apb(1'b1, 12'h140, 32'h00880100);
        gap(0, 1'b0, g);
        chk(g, 32'hC);
        gap(0, 1'b0, g);
        chk(g, 32'h4);
        apb(1'b1, 12'h140, 32'h01900100);
        apb(1'b0, 12'h144, 32'h0);
        s = rd_q;
        apb(1'b0, 12'h144, 32'h0);
        chk(rd_q, s);
        apb(1'b1, 12'h140, 32'h02900100);
        apb(1'b0, 12'h144, 32'h0);
        chk(rd_q, 32'h0);
        apb(1'b1, 12'h140, 32'h00900100);
        $display("timer test done");
    endtask : t_timer

    task automatic t_pwm;
        apb(1'b1, 12'h004, 32'h2);
        apb(1'b1, 12'h008, 32'h50);
        win(1'b0);
        chk({16'h0, h}, 32'h50);
        chk({16'h0, r}, 32'h10);
        apb(1'b1, 12'h008, 32'h58);
        win(1'b0);
        chk({16'h0, h}, 32'h58);
        $display("pwm test done");
    endtask : t_pwm

    task automatic t_fade;
        apb(1'b1, 12'h008, 32'h50);
        apb(1'b1, 12'h00C, 32'hC0300402);
        wait_done;
        apb(1'b0, 12'h010, 32'h0);
        chk(rd_q, 32'hB0);
        apb(1'b1, 12'h00C, 32'h80200401);
        wait_done;
        apb(1'b0, 12'h010, 32'h0);
        chk(rd_q, 32'h90);
        $display("fade test done");
    endtask : t_fade

    task automatic t_slow;
        apb(1'b1, 12'h190, 32'h1);
        apb(1'b1, 12'h168, 32'h008C0100);
        gap(5, 1'b1, g);
        chk({31'h0, g == 8}, 32'h0);
        apb(1'b1, 12'h168, 32'h048C0100);
        gap(5, 1'b1, g);
        chk(g, 32'h8);
        apb(1'b1, 12'h190, 32'h0);
        gap(5, 1'b1, g);
        gap(5, 1'b0, g);
        chk(g, 32'h10);
        apb(1'b1, 12'h190, 32'h1);
        apb(1'b1, 12'h0A0, 32'h1);
        apb(1'b1, 12'h0A8, 32'h30);
        win(1'b1);
        chk({16'h0, h}, 32'h60);
        apb(1'b1, 12'h0AC, 32'hC0100401);
        wait_done;
        apb(1'b0, 12'h0B0, 32'h0);
        chk(rd_q, 32'h40);
        $display("slow test done");
    endtask : t_slow

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // main sequence, all inputs defined at time zero
    initial
    begin
        {rstn, psel, penable, pwrite, clr, use_slow, ref_tick_pin, clk8m_pin} = 8'h0;
        {paddr, pwdata, div_cnt} = '0;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        t_regs;
        t_timer;
        t_pwm;
        t_fade;
        t_slow;
        complete_run;
    end

    // hang guard: the tests need well under this many cycles
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        fail_count++;
        complete_run;
    end
endmodule : tb_top
`default_nettype wire
